// ---- rtl/dcc_regs.svh ----
// Register addresses, bit positions, reset values and hysteresis levels
// of the dual comparator control block.
// Assumes inclusion by bare name from files under rtl/.
`ifndef DCC_REGS_SVH
`define DCC_REGS_SVH

`define DCC_ADDR_CTL0 8'h9b
`define DCC_ADDR_CTL1 8'h9a
`define DCC_ADDR_MODE0 8'h9d
`define DCC_ADDR_MODE1 8'h9c

`define DCC_CTL_EN_BIT 7
`define DCC_CTL_RES_BIT 6
`define DCC_CTL_RISE_BIT 5
`define DCC_CTL_FALL_BIT 4
`define DCC_CTL_HYP_HI 3
`define DCC_CTL_HYP_LO 2
`define DCC_CTL_HYN_HI 1
`define DCC_CTL_HYN_LO 0

`define DCC_MODE_RIE_BIT 5
`define DCC_MODE_FIE_BIT 4
`define DCC_MODE_MD_HI 1
`define DCC_MODE_MD_LO 0

`define DCC_EN_RESET 1'b0
`define DCC_FLAG_RESET 1'b0
`define DCC_HYST_RESET 2'h0
`define DCC_IE_RESET 1'b0
`define DCC_SPEED_RESET 2'h2
`define DCC_SYNC_RESET 1'b0
`define DCC_RDATA_RESET 8'h00
`define DCC_RDATA_UNMAPPED 8'h00
`define DCC_MODE_RSV_READ 1'b1
`define DCC_MODE_UNUSED6 1'b0
`define DCC_MODE_UNUSED32 2'h0

`define DCC_HYST_L0_MV 'h0000
`define DCC_HYST_L1_MV 'h0005
`define DCC_HYST_L2_MV 'h000a
`define DCC_HYST_L3_MV 'h0014

`endif

// ---- rtl/dcc_pkg.sv ----
// Types shared by the dual comparator control block.
// Assumes nothing of its surroundings.
package dcc_pkg;
  typedef enum logic [1:0] {
    DCC_SPEED_M0 = 2'h0,
    DCC_SPEED_M1 = 2'h1,
    DCC_SPEED_M2 = 2'h2,
    DCC_SPEED_M3 = 2'h3
  } dcc_speed_t;

  typedef enum logic [1:0] {
    DCC_HYST_OFF = 2'h0,
    DCC_HYST_L1 = 2'h1,
    DCC_HYST_L2 = 2'h2,
    DCC_HYST_L3 = 2'h3
  } dcc_hyst_t;
endpackage

// ---- rtl/dcc_chan.sv ----
// One comparator channel: behavioural decision with hysteresis, the raw
// output, the clock synchroniser and edge detection.
// Assumes input levels are unsigned millivolt codes synchronous to clk_sys.
`timescale 1ns/1ns
`default_nettype none
`include "dcc_regs.svh"
module dcc_chan #(
  parameter int VW = 12
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic enable,
  input wire logic [VW-1:0] pos_in,
  input wire logic [VW-1:0] neg_in,
  input wire logic [1:0] hyst_pos,
  input wire logic [1:0] hyst_neg,
  output logic raw_out,
  output logic synced_out,
  output logic rise_pulse,
  output logic fall_pulse
);
  function automatic logic [VW:0] hyst_mv(input logic [1:0] code);
    logic [VW:0] mv;
    mv = '0;
    unique case (dcc_pkg::dcc_hyst_t'(code))
      dcc_pkg::DCC_HYST_OFF: mv = (VW+1)'(`DCC_HYST_L0_MV);
      dcc_pkg::DCC_HYST_L1: mv = (VW+1)'(`DCC_HYST_L1_MV);
      dcc_pkg::DCC_HYST_L2: mv = (VW+1)'(`DCC_HYST_L2_MV);
      dcc_pkg::DCC_HYST_L3: mv = (VW+1)'(`DCC_HYST_L3_MV);
    endcase
    return mv;
  endfunction

  logic s1_r, s2_r, s3_r;
  wire [VW:0] pos_ext = {1'b0, pos_in};
  wire [VW:0] neg_ext = {1'b0, neg_in};
  wire [VW:0] hp_mv = hyst_mv(hyst_pos);
  wire [VW:0] hn_mv = hyst_mv(hyst_neg);
  // Widened sums avoid wrap at the top of the input range
  wire rise_cond = pos_ext > (neg_ext + hp_mv);
  wire fall_cond = (pos_ext + hn_mv) <= neg_ext;
  // Held state is the synchronised output; with the clock stopped the
  // threshold stays where it was, but the raw path still answers.
  assign raw_out = enable & (s2_r ? ~fall_cond : rise_cond);

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      s1_r <= `DCC_SYNC_RESET;
      s2_r <= `DCC_SYNC_RESET;
      s3_r <= `DCC_SYNC_RESET;
    end else if (ce) begin
      s1_r <= raw_out;
      s2_r <= s1_r;
      s3_r <= s2_r;
    end
  end

  assign synced_out = s2_r;
  assign rise_pulse = ce & s2_r & ~s3_r;
  assign fall_pulse = ce & ~s2_r & s3_r;

  property p_pos_hyst;
    @(posedge clk_sys) disable iff (sys_rst)
    (enable && !s2_r && raw_out) |-> (pos_ext > neg_ext + hp_mv);
  endproperty
  a_pos_hyst: assert property (p_pos_hyst) else $error("rise before positive hysteresis");

  property p_neg_hyst;
    @(posedge clk_sys) disable iff (sys_rst)
    (enable && s2_r && !raw_out) |-> (pos_ext + hn_mv <= neg_ext);
  endproperty
  a_neg_hyst: assert property (p_neg_hyst) else $error("fall before negative hysteresis");
endmodule
`default_nettype wire

// ---- rtl/dcc_top.sv ----
// Dual comparator control: special-register file, edge flags and
// interrupt request gating around two identical comparator channels.
// Assumes a one-cycle special-register bus synchronous to clk_sys and
// comparator input levels given as millivolt codes.
//
// How it works
// - With both hysteresis levels at 0, enabled comparator output is high exactly when positive input exceeds negative.
// - A disabled comparator's output is forced low.
// - Each output is synchronised to clk_sys for status, flags and routing.
// - An unsynchronised raw output is provided and needs no clock.
// - Rising and falling edges set their flags regardless of interrupt enables.
// - Edge flags stay set until software writes them to zero.
// - Interrupt needs flag with its enable, source enable and global enable.
// - Four response-time modes, mode 0 fastest, mode 3 lowest power.
// - Disabled comparator is held in low power shutdown.
// - Positive hysteresis delays the rise by the programmed amount.
// - Negative hysteresis delays the fall by the programmed amount.
// - Hysteresis levels of 0, 5, 10 and 20 mV, set per direction.
// - Control bit 7 enables the comparator; clearing it disables it.
// - Control bit 6 reads the synchronised result and is read-only.
// - Rise flag at bit 5, fall flag at bit 4, both writable.
// - Control bits 3:2 select positive hysteresis level.
// - Control bits 1:0 select negative hysteresis level.
// - The second comparator is an identical instance with its own settings.
// - Mode bits 5 and 4 enable rise and fall interrupts, reset zero.
// - Mode bits 1:0 pick response time, resetting to 10.
`timescale 1ns/1ns
`default_nettype none
`include "dcc_regs.svh"
module dcc_top #(
  parameter int VW = 12
) (
  input wire logic clk_sys,
  input wire logic sys_rst,
  input wire logic ce,
  input wire logic [7:0] sfr_addr,
  input wire logic sfr_wr,
  input wire logic sfr_rd,
  input wire logic [7:0] sfr_wdata,
  output logic [7:0] sfr_rdata,
  input wire logic [VW-1:0] cmp_zero_pos_in,
  input wire logic [VW-1:0] cmp_zero_neg_in,
  input wire logic [VW-1:0] cmp_one_pos_in,
  input wire logic [VW-1:0] cmp_one_neg_in,
  input wire logic [1:0] cmp_irq_src_en,
  input wire logic global_irq_en,
  output logic cmp_zero_raw_out,
  output logic cmp_one_raw_out,
  output logic cmp_zero_synced_out,
  output logic cmp_one_synced_out,
  output logic [1:0] cmp_irq_req,
  output logic [1:0] cmp_zero_speed_sel,
  output logic [1:0] cmp_one_speed_sel,
  output logic [1:0] cmp_shutdown
);
  localparam int NCH = 2;

  logic [NCH-1:0] en_r, en_nxt;
  logic [NCH-1:0] rflag_r, rflag_nxt;
  logic [NCH-1:0] fflag_r, fflag_nxt;
  logic [NCH-1:0] rie_r, rie_nxt;
  logic [NCH-1:0] fie_r, fie_nxt;
  logic [NCH-1:0][1:0] hyp_r, hyp_nxt;
  logic [NCH-1:0][1:0] hyn_r, hyn_nxt;
  logic [NCH-1:0][1:0] speed_r, speed_nxt;
  logic [7:0] rdata_r, rdata_nxt;

  logic [NCH-1:0][VW-1:0] pos_in, neg_in;
  logic [NCH-1:0][7:0] ctl_addr, mode_addr, ctl_view, mode_view;
  logic [NCH-1:0] ctl_wr, mode_wr, ctl_sel, mode_sel;
  logic [NCH-1:0] raw, synced, rise, fall, irq;

  assign pos_in[0] = cmp_zero_pos_in;
  assign neg_in[0] = cmp_zero_neg_in;
  assign pos_in[1] = cmp_one_pos_in;
  assign neg_in[1] = cmp_one_neg_in;
  assign ctl_addr[0] = `DCC_ADDR_CTL0;
  assign ctl_addr[1] = `DCC_ADDR_CTL1;
  assign mode_addr[0] = `DCC_ADDR_MODE0;
  assign mode_addr[1] = `DCC_ADDR_MODE1;

  genvar gi;
  generate
    for (gi = 0; gi < NCH; gi++) begin : g_ch
      dcc_chan #(
        .VW(VW)
      ) u_chan (
        .clk_sys(clk_sys),
        .sys_rst(sys_rst),
        .ce(ce),
        .enable(en_r[gi]),
        .pos_in(pos_in[gi]),
        .neg_in(neg_in[gi]),
        .hyst_pos(hyp_r[gi]),
        .hyst_neg(hyn_r[gi]),
        .raw_out(raw[gi]),
        .synced_out(synced[gi]),
        .rise_pulse(rise[gi]),
        .fall_pulse(fall[gi])
      );

      assign ctl_sel[gi] = sfr_addr == ctl_addr[gi];
      assign mode_sel[gi] = sfr_addr == mode_addr[gi];
      assign ctl_wr[gi] = sfr_wr & ctl_sel[gi];
      assign mode_wr[gi] = sfr_wr & mode_sel[gi];

      assign en_nxt[gi] = ctl_wr[gi] ? sfr_wdata[`DCC_CTL_EN_BIT] : en_r[gi];
      assign hyp_nxt[gi] = ctl_wr[gi] ?
                           sfr_wdata[`DCC_CTL_HYP_HI:`DCC_CTL_HYP_LO] : hyp_r[gi];
      assign hyn_nxt[gi] = ctl_wr[gi] ?
                           sfr_wdata[`DCC_CTL_HYN_HI:`DCC_CTL_HYN_LO] : hyn_r[gi];
      // Set wins over a clearing write in the same cycle
      assign rflag_nxt[gi] = rise[gi] |
                             (ctl_wr[gi] ? sfr_wdata[`DCC_CTL_RISE_BIT] : rflag_r[gi]);
      assign fflag_nxt[gi] = fall[gi] |
                             (ctl_wr[gi] ? sfr_wdata[`DCC_CTL_FALL_BIT] : fflag_r[gi]);
      assign rie_nxt[gi] = mode_wr[gi] ? sfr_wdata[`DCC_MODE_RIE_BIT] : rie_r[gi];
      assign fie_nxt[gi] = mode_wr[gi] ? sfr_wdata[`DCC_MODE_FIE_BIT] : fie_r[gi];
      assign speed_nxt[gi] = mode_wr[gi] ?
                             sfr_wdata[`DCC_MODE_MD_HI:`DCC_MODE_MD_LO] : speed_r[gi];

      // Result bit is live status; writes to it are dropped
      assign ctl_view[gi] = {en_r[gi], synced[gi], rflag_r[gi], fflag_r[gi],
                             hyp_r[gi], hyn_r[gi]};
      assign mode_view[gi] = {`DCC_MODE_RSV_READ, `DCC_MODE_UNUSED6, rie_r[gi], fie_r[gi],
                              `DCC_MODE_UNUSED32, speed_r[gi]};

      assign irq[gi] = ((rflag_r[gi] & rie_r[gi]) | (fflag_r[gi] & fie_r[gi])) &
                       cmp_irq_src_en[gi] & global_irq_en;

      sequence s_rise_seen;
        rise[gi] ##1 rflag_r[gi];
      endsequence

      sequence s_fall_seen;
        fall[gi] ##1 fflag_r[gi];
      endsequence

      property p_disabled_low;
        @(posedge clk_sys) disable iff (sys_rst)
        !en_r[gi] |-> !raw[gi] ##2 (!synced[gi] || !$past(ce) || !$past(ce, 2));
      endproperty
      a_disabled_low: assert property (p_disabled_low) else $error("disabled output high");

      property p_plain_compare;
        @(posedge clk_sys) disable iff (sys_rst)
        (en_r[gi] && hyp_r[gi] == `DCC_HYST_RESET && hyn_r[gi] == `DCC_HYST_RESET) |->
          raw[gi] == (pos_in[gi] > neg_in[gi]);
      endproperty
      a_plain_compare: assert property (p_plain_compare) else $error("compare wrong");

      property p_sync_delay;
        @(posedge clk_sys) disable iff (sys_rst)
        ($past(ce) && $past(ce, 2) && !$past(sys_rst, 2) && !$past(sys_rst, 3)) |->
          synced[gi] == $past(raw[gi], 2);
      endproperty
      a_sync_delay: assert property (p_sync_delay) else $error("sync delay not two");

      property p_rise_flag;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && synced[gi] && !$past(synced[gi]) && !$past(sys_rst)) |-> s_rise_seen;
      endproperty
      a_rise_flag: assert property (p_rise_flag) else $error("rise flag not set");

      property p_fall_flag;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && !synced[gi] && $past(synced[gi]) && !$past(sys_rst)) |-> s_fall_seen;
      endproperty
      a_fall_flag: assert property (p_fall_flag) else $error("fall flag not set");

      property p_flag_sticky;
        @(posedge clk_sys) disable iff (sys_rst)
        (rflag_r[gi] && !(ce && ctl_wr[gi] && !sfr_wdata[`DCC_CTL_RISE_BIT])) |=>
          rflag_r[gi];
      endproperty
      a_flag_sticky: assert property (p_flag_sticky) else $error("rise flag lost");

      property p_fall_sticky;
        @(posedge clk_sys) disable iff (sys_rst)
        (fflag_r[gi] && !(ce && ctl_wr[gi] && !sfr_wdata[`DCC_CTL_FALL_BIT])) |=>
          fflag_r[gi];
      endproperty
      a_fall_sticky: assert property (p_fall_sticky) else $error("fall flag lost");

      property p_irq_gate;
        @(posedge clk_sys) disable iff (sys_rst)
        cmp_irq_req[gi] |-> (global_irq_en && cmp_irq_src_en[gi] &&
          ((rflag_r[gi] && rie_r[gi]) || (fflag_r[gi] && fie_r[gi])));
      endproperty
      a_irq_gate: assert property (p_irq_gate) else $error("interrupt not gated");

      property p_edge_once;
        @(posedge clk_sys) disable iff (sys_rst)
        rise[gi] |=> !rise[gi];
      endproperty
      a_edge_once: assert property (p_edge_once) else $error("edge seen twice");

      property p_status_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && sfr_rd && ctl_sel[gi]) |=>
          sfr_rdata[`DCC_CTL_RES_BIT] == $past(synced[gi]);
      endproperty
      a_status_read: assert property (p_status_read) else $error("result bit wrong");

      property p_enable_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && ctl_wr[gi]) |=> en_r[gi] == $past(sfr_wdata[`DCC_CTL_EN_BIT]) &&
          cmp_shutdown[gi] == !$past(sfr_wdata[`DCC_CTL_EN_BIT]);
      endproperty
      a_enable_write: assert property (p_enable_write) else $error("enable write lost");

      property p_hyst_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && ctl_wr[gi]) |=>
          hyp_r[gi] == $past(sfr_wdata[`DCC_CTL_HYP_HI:`DCC_CTL_HYP_LO]) &&
          hyn_r[gi] == $past(sfr_wdata[`DCC_CTL_HYN_HI:`DCC_CTL_HYN_LO]);
      endproperty
      a_hyst_write: assert property (p_hyst_write) else $error("hyst write lost");

      property p_mode_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && mode_wr[gi]) |=>
          rie_r[gi] == $past(sfr_wdata[`DCC_MODE_RIE_BIT]) &&
          fie_r[gi] == $past(sfr_wdata[`DCC_MODE_FIE_BIT]);
      endproperty
      a_mode_write: assert property (p_mode_write) else $error("irq enable write lost");

      property p_speed_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && mode_wr[gi]) |=>
          speed_r[gi] == $past(sfr_wdata[`DCC_MODE_MD_HI:`DCC_MODE_MD_LO]);
      endproperty
      a_speed_write: assert property (p_speed_write) else $error("speed write lost");

      property p_flag_write;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && ctl_wr[gi] && !rise[gi] && !fall[gi]) |=>
          rflag_r[gi] == $past(sfr_wdata[`DCC_CTL_RISE_BIT]) &&
          fflag_r[gi] == $past(sfr_wdata[`DCC_CTL_FALL_BIT]);
      endproperty
      a_flag_write: assert property (p_flag_write) else $error("flag write lost");

      property p_irq_raise;
        @(posedge clk_sys) disable iff (sys_rst)
        (global_irq_en && cmp_irq_src_en[gi] &&
          ((rflag_r[gi] && rie_r[gi]) || (fflag_r[gi] && fie_r[gi]))) |-> cmp_irq_req[gi];
      endproperty
      a_irq_raise: assert property (p_irq_raise) else $error("interrupt not raised");

      property p_fall_once;
        @(posedge clk_sys) disable iff (sys_rst)
        fall[gi] |=> !fall[gi];
      endproperty
      a_fall_once: assert property (p_fall_once) else $error("fall seen twice");

      // Read shows the old fields even when a write shares the cycle
      property p_mode_read;
        @(posedge clk_sys) disable iff (sys_rst)
        (ce && sfr_rd && mode_sel[gi]) |=>
          sfr_rdata[`DCC_MODE_RIE_BIT] == $past(rie_r[gi]) &&
          sfr_rdata[`DCC_MODE_FIE_BIT] == $past(fie_r[gi]) &&
          sfr_rdata[`DCC_MODE_MD_HI:`DCC_MODE_MD_LO] == $past(speed_r[gi]);
      endproperty
      a_mode_read: assert property (p_mode_read) else $error("mode read wrong");

      // A low clock enable must hold the enable, both edge flags and the synchronised output
      property p_ce_freeze;
        @(posedge clk_sys) disable iff (sys_rst)
        !ce |=> en_r[gi] == $past(en_r[gi]) && rflag_r[gi] == $past(rflag_r[gi]) &&
          fflag_r[gi] == $past(fflag_r[gi]) && synced[gi] == $past(synced[gi]);
      endproperty
      a_ce_freeze: assert property (p_ce_freeze) else $error("state moved with ce low");
    end
  endgenerate

  assign rdata_nxt = ctl_sel[0] ? ctl_view[0] :
                     ctl_sel[1] ? ctl_view[1] :
                     mode_sel[0] ? mode_view[0] :
                     mode_sel[1] ? mode_view[1] : `DCC_RDATA_UNMAPPED;

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      en_r <= {NCH{`DCC_EN_RESET}};
      rflag_r <= {NCH{`DCC_FLAG_RESET}};
      fflag_r <= {NCH{`DCC_FLAG_RESET}};
      hyp_r <= {NCH{`DCC_HYST_RESET}};
      hyn_r <= {NCH{`DCC_HYST_RESET}};
    end else if (ce) begin
      en_r <= en_nxt;
      rflag_r <= rflag_nxt;
      fflag_r <= fflag_nxt;
      hyp_r <= hyp_nxt;
      hyn_r <= hyn_nxt;
    end
  end

  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rie_r <= {NCH{`DCC_IE_RESET}};
      fie_r <= {NCH{`DCC_IE_RESET}};
      speed_r <= {NCH{`DCC_SPEED_RESET}};
    end else if (ce) begin
      rie_r <= rie_nxt;
      fie_r <= fie_nxt;
      speed_r <= speed_nxt;
    end
  end

  // Read data holds between reads so a slow core can sample late
  always_ff @(posedge clk_sys or posedge sys_rst) begin
    if (sys_rst) begin
      rdata_r <= `DCC_RDATA_RESET;
    end else if (ce && sfr_rd) begin
      rdata_r <= rdata_nxt;
    end
  end

  assign sfr_rdata = rdata_r;
  assign cmp_zero_raw_out = raw[0];
  assign cmp_one_raw_out = raw[1];
  assign cmp_zero_synced_out = synced[0];
  assign cmp_one_synced_out = synced[1];
  assign cmp_irq_req = irq;
  // Speed code drives the analogue bias; slower code means lower current
  assign cmp_zero_speed_sel = speed_r[0];
  assign cmp_one_speed_sel = speed_r[1];
  assign cmp_shutdown = ~en_r;

  property p_speed_reset;
    @(posedge clk_sys)
    $fell(sys_rst) |-> (cmp_zero_speed_sel == `DCC_SPEED_RESET &&
      cmp_one_speed_sel == `DCC_SPEED_RESET && rie_r == '0 && fie_r == '0);
  endproperty
  a_speed_reset: assert property (p_speed_reset) else $error("mode reset wrong");

  property p_ctl_reset;
    @(posedge clk_sys)
    $fell(sys_rst) |-> (en_r == '0 && rflag_r == '0 && fflag_r == '0 &&
      hyp_r == '0 && hyn_r == '0 && cmp_shutdown == 2'h3);
  endproperty
  a_ctl_reset: assert property (p_ctl_reset) else $error("control reset wrong");

  property p_unmapped_read;
    @(posedge clk_sys) disable iff (sys_rst)
    (ce && sfr_rd && !(|ctl_sel) && !(|mode_sel)) |=> sfr_rdata == `DCC_RDATA_UNMAPPED;
  endproperty
  a_unmapped_read: assert property (p_unmapped_read) else $error("unmapped read not zero");
endmodule
`default_nettype wire

// ---- verif/dcc_cpu_model.sv ----
// CPU-side model: special-register bus master for the comparator block.
// Assumes one-cycle strobes sampled on the rising edge of clk_sys.
`timescale 1ns/1ns
`default_nettype none
module dcc_cpu_model (
  input wire logic clk_sys,
  output var logic [7:0] sfr_addr,
  output var logic sfr_wr,
  output var logic sfr_rd,
  output var logic [7:0] sfr_wdata
);
  initial begin
    sfr_addr = 8'h00;
    sfr_wr = 1'b0;
    sfr_rd = 1'b0;
    sfr_wdata = 8'h00;
  end

  // Idle lines are inverted so a stale address or datum never looks valid
  task automatic cyc(input logic [7:0] a, input logic [7:0] d, input logic w);
    @(posedge clk_sys);
    sfr_addr <= a;
    sfr_wdata <= d;
    sfr_wr <= w;
    sfr_rd <= ~w;
    @(posedge clk_sys);
    sfr_wr <= 1'b0;
    sfr_rd <= 1'b0;
    sfr_addr <= ~a;
    sfr_wdata <= ~d;
  endtask

  // Enable first, then wipe edges caught while the comparator settles
  task automatic enable_chan(input logic [7:0] a, input logic [7:0] hyst);
    cyc(a, 8'h80 | hyst, 1'b1);
    repeat (3) @(posedge clk_sys);
    cyc(a, 8'h80 | hyst, 1'b1);
  endtask
endmodule
`default_nettype wire

// ---- verif/dcc_top_tb.sv ----
// Self-checking bench for the dual comparator control block.
// Assumes the bus model dcc_cpu_model and a 50 MHz system clock.
`timescale 1ns/1ns
`default_nettype none
`include "dcc_regs.svh"
module dcc_top_tb;
  logic clk_sys;
  logic sys_rst;
  logic ce;
  logic glob;
  logic rd_d = 1'b0;
  logic [1:0] src_en;
  logic [11:0] pos [2];
  logic [11:0] neg [2];
  logic [7:0] exp_q [$];
  logic [11:0] hmv;
  wire [7:0] sfr_addr;
  wire [7:0] sfr_wdata;
  wire [7:0] sfr_rdata;
  wire sfr_wr;
  wire sfr_rd;
  wire [1:0] raw;
  wire [1:0] syn;
  wire [1:0] irq;
  wire [1:0] shut;
  wire [3:0] spd;
  int n_mismatch = 0;
  int n_compared = 0;
  int ch;
  int k;
  int unsigned base;

  dcc_cpu_model i_cpu (
    .clk_sys(clk_sys), .sfr_addr(sfr_addr), .sfr_wr(sfr_wr), .sfr_rd(sfr_rd),
    .sfr_wdata(sfr_wdata)
  );
  dcc_top #(.VW(12)) i_dut (
    .clk_sys(clk_sys), .sys_rst(sys_rst), .ce(ce), .sfr_addr(sfr_addr),
    .sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
    .cmp_zero_pos_in(pos[0]), .cmp_zero_neg_in(neg[0]),
    .cmp_one_pos_in(pos[1]), .cmp_one_neg_in(neg[1]),
    .cmp_irq_src_en(src_en), .global_irq_en(glob),
    .cmp_zero_raw_out(raw[0]), .cmp_one_raw_out(raw[1]),
    .cmp_zero_synced_out(syn[0]), .cmp_one_synced_out(syn[1]),
    .cmp_irq_req(irq), .cmp_zero_speed_sel(spd[1:0]), .cmp_one_speed_sel(spd[3:2]),
    .cmp_shutdown(shut)
  );

  initial begin
    clk_sys = 1'b0;
    forever #10 clk_sys = ~clk_sys;
  end

  task automatic check(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      n_mismatch++;
      $display("BAD %0t got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic give_verdict();
    $display("compared %0d mismatched %0d", n_compared, n_mismatch);
    if (n_mismatch == 0 && n_compared > 0) begin
      $display("STATUS OK");
    end else begin
      $display("STATUS NOT OK");
    end
    $finish;
  endtask

  function automatic logic [7:0] ctla(input int c);
    return (c != 0) ? `DCC_ADDR_CTL1 : `DCC_ADDR_CTL0;
  endfunction

  function automatic logic [7:0] moda(input int c);
    return (c != 0) ? `DCC_ADDR_MODE1 : `DCC_ADDR_MODE0;
  endfunction

  function automatic logic [7:0] cv(input logic en, input logic res, input logic rf,
                                    input logic ff, input logic [3:0] hy);
    return {en, res, rf, ff, hy};
  endfunction

  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    i_cpu.cyc(a, d, 1'b1);
  endtask

  // Expected read data waits in the queue until the monitor sees rdata
  task automatic rd_chk(input logic [7:0] a, input logic [7:0] e);
    i_cpu.cyc(a, 8'h00, 1'b0);
    exp_q.push_back(e);
  endtask

  // Drive the positive input, then look after the full sync latency
  task step(input logic [11:0] v, input logic e);
    @(posedge clk_sys);
    pos[ch] <= v;
    repeat (3) @(posedge clk_sys);
    @(negedge clk_sys);
    check(8'(syn[ch]), 8'(e));
  endtask

  always @(posedge clk_sys) rd_d <= sfr_rd & ce & ~sys_rst;

  always @(negedge clk_sys) begin
    if (rd_d && exp_q.size() > 0) begin
      check(sfr_rdata, exp_q.pop_front());
    end
  end

  initial begin
    #400_000;
    n_mismatch++;
    give_verdict();
  end

  initial begin
    void'($urandom(47));
    sys_rst = 1'b1;
    ce = 1'b1;
    glob = 1'b0;
    src_en = 2'b00;
    pos = '{12'h000, 12'h000};
    neg = '{12'h000, 12'h000};
    repeat (3) @(posedge clk_sys);
    sys_rst <= 1'b0;
    @(negedge clk_sys);
    check(8'(shut), 8'h03);
    check(8'(spd), 8'h0a);
    rd_chk(8'h00, 8'h00);
    for (ch = 0; ch < 2; ch++) begin
      rd_chk(ctla(ch), 8'h00);
      rd_chk(moda(ch), 8'h82);
    end
    for (ch = 0; ch < 2; ch++) begin
      base = 100 + $urandom % 900;
      @(posedge clk_sys);
      pos[ch] <= 12'(base);
      neg[ch] <= 12'(base);
      i_cpu.enable_chan(ctla(ch), 8'h00);
      @(negedge clk_sys);
      check(8'(shut[ch]), 8'h00);
      // Reserved mode bit 7 is always written as one
      for (k = 0; k < 4; k++) begin
        wr(moda(ch), 8'h80 | 8'(k));
        @(negedge clk_sys);
        check(8'(spd[2*ch +: 2]), 8'(k));
      end
      wr(moda(ch), 8'hb2);
      rd_chk(moda(ch), 8'hb2);
      src_en[ch] <= 1'b1;
      glob <= 1'b1;
      pos[ch] <= 12'(base + 1);
      @(negedge clk_sys);
      check(8'(raw[ch]), 8'h01);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check(8'({syn[ch], irq[ch]}), 8'h02);
      @(negedge clk_sys);
      check(8'(irq[ch]), 8'h01);
      for (k = 0; k < 4; k++) begin
        @(posedge clk_sys);
        {src_en[ch], glob} <= 2'(k);
        @(negedge clk_sys);
        check(8'(irq[ch]), 8'(k == 3));
      end
      rd_chk(ctla(ch), cv(1'b1, 1'b1, 1'b1, 1'b0, 4'h0));
      wr(moda(ch), 8'h92);
      @(negedge clk_sys);
      check(8'(irq[ch]), 8'h00);
      step(12'(base), 1'b0);
      check(8'(irq[ch]), 8'h01);
      rd_chk(ctla(ch), cv(1'b1, 1'b0, 1'b1, 1'b1, 4'h0));
      wr(ctla(ch), 8'hc0);
      repeat (4) @(posedge clk_sys);
      rd_chk(ctla(ch), 8'h80);
      for (k = 0; k < 4; k++) begin
        hmv = (k == 3) ? 12'h014 : 12'(k * 5);
        wr(ctla(ch), cv(1'b1, 1'b0, 1'b0, 1'b0, {2'(k), 2'(k)}));
        step(12'(base) + hmv, 1'b0);
        step(12'(base) + hmv + 12'h001, 1'b1);
        step(12'(base) - hmv + 12'h001, 1'b1);
        step(12'(base) - hmv, 1'b0);
      end
      step(12'(base + 30), 1'b1);
      wr(ctla(ch), 8'h00);
      @(negedge clk_sys);
      check(8'({raw[ch], shut[ch]}), 8'h01);
      repeat (2) @(posedge clk_sys);
      @(negedge clk_sys);
      check(8'(syn[ch]), 8'h00);
    end
    // Writes with the clock enable low must leave the register alone
    @(posedge clk_sys);
    ce <= 1'b0;
    wr(ctla(0), 8'h80);
    ce <= 1'b1;
    rd_chk(ctla(0), 8'h10);
    repeat (2) @(posedge clk_sys);
    // A read that never answered leaves its note behind
    check(8'(exp_q.size()), 8'h00);
    give_verdict();
  end
endmodule
`default_nettype wire
